// ==== shared/pms_map.svh ====
// Register offsets, field positions, reset values and timing counts of the power mode sequencer
// How it works
// - Pins decode high-then-low: 01 normal, 00 reduced, 10 low power, 11 sleep.
// - The full variant supports four modes; reduced variants support only two.
// - Reduced variants offer only normal and sleep; reduced and low-power do not exist.
// - Mode pins are pulled up, so undriven pins decode as sleep.
// - Entering normal from another mode reloads control registers, except threshold and config.
// - Finishing the transition drives the second interrupt low and sets done flag bit 15.
// - The done flag reads zero throughout the transition and one once finished.
// - Writing status with bit 15 set clears the flag and releases the interrupt.
// - Mask bit 15 has no effect; the done event always asserts the interrupt.
// - Both interrupt outputs are active low, held high when idle.
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_MASK 8'h04
`define OFS_THRESH 8'h08
`define OFS_CFG2 8'h0C
`define OFS_STATUS 8'h10
`define OFS_CLEAR 8'h14
`define OFS_MODE 8'h18
`define OFS_COUNT 8'h1C

// Status, clear and mask bit positions
`define BIT_MODE_CHANGE 0
`define BIT_UNSUPPORTED 1
`define BIT_DONE 15

// Control register fields
`define BIT_CTRL_REPORT 0

// Reset values
`define RST_CTRL 16'h0001
`define RST_MASK 16'h0000
`define RST_THRESH 8'h07
`define RST_CFG2 8'h00

// Timing: restore period and clock
`define RESTORE_NS 80
`define CLK_PERIOD_NS 5
`define RESTORE_CYC ((`RESTORE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== shared/pms_pkg.sv ====
// Types shared by the power mode sequencer modules
package pms_pkg;

  // Encoding is {high pin, low pin}
  typedef enum logic [1:0] {
    reduced_power_mode = 2'h0,
    normal_power_mode = 2'h1,
    low_power_mode = 2'h2,
    sleep_power_mode = 2'h3
  } power_mode_t;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_restore = 3'h2,
    st_finish = 3'h4
  } seq_state_t;

endpackage

// ==== shared/mode_if.sv ====
// Decoded mode request travelling from the pin decoder to the sequencer
`timescale 1ns/10ps
`default_nettype none
interface mode_if;
  import pms_pkg::*;
  power_mode_t req_mode;
  logic [1:0] raw_code;
  logic change;
  logic unsupported;
  modport src (output req_mode, output raw_code, output change, output unsupported);
  modport dst (input req_mode, input raw_code, input change, input unsupported);
endinterface
`default_nettype wire

// ==== verilog/mode_pin_decoder.sv ====
// Synchroniser and decoder for the two mode-select pins
`timescale 1ns/10ps
`default_nettype none
module mode_pin_decoder
  import pms_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic mode_select_low_pin_i,
  input wire logic mode_select_high_pin_i,
  mode_if.src mif
);

  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  power_mode_t last_r;
  logic [1:0] last_raw_r;
  power_mode_t dec_mode;
  logic dec_unsup;

  // Two-stage synchroniser; resets high as pulled-up pins read
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
    end else begin
      sync1_r <= {mode_select_high_pin_i, mode_select_low_pin_i};
      sync2_r <= sync1_r;
    end
  end

  // Pin code to mode; reduced variants fold missing modes into sleep
  assign dec_unsup = !FULL_VARIANT && (sync2_r == reduced_power_mode ||
                                       sync2_r == low_power_mode);
  assign dec_mode = dec_unsup ? sleep_power_mode : power_mode_t'(sync2_r);

  // Remember last decoded mode and raw code so only a new encoding counts
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      last_r <= sleep_power_mode;
      last_raw_r <= 2'h3;
    end else begin
      last_r <= dec_mode;
      last_raw_r <= sync2_r;
    end
  end

  assign mif.req_mode = dec_mode;
  assign mif.raw_code = sync2_r;
  // Folded codes still count as a change; only the settled second stage is read
  assign mif.change = (dec_mode != last_r) || (dec_unsup && sync2_r != last_raw_r);
  assign mif.unsupported = dec_unsup;

endmodule
`default_nettype wire

// ==== verilog/power_mode_select_sequencer.sv ====
// Power mode sequencer: pin decode, register restore on wake, done flag and interrupts
`timescale 1ns/10ps
`default_nettype none
`include "pms_map.svh"
module power_mode_select_sequencer
  import pms_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1,
  parameter int RESTORE_CYCLES = `RESTORE_CYC,
  parameter logic [15:0] CTRL_DEFAULT = `RST_CTRL,
  parameter logic [15:0] MASK_DEFAULT = `RST_MASK
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic mode_select_low_pin_i,
  input wire logic mode_select_high_pin_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic first_interrupt_out_n_o,
  output logic second_interrupt_out_n_o,
  output logic [1:0] power_mode_o,
  output logic transition_busy_o
);

  localparam int CNT_W = (RESTORE_CYCLES > 1) ? $clog2(RESTORE_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESTORE_CYCLES - 1);

  mode_if mif ();

  // Synchronised and decoded mode pins
  mode_pin_decoder #(
    .FULL_VARIANT(FULL_VARIANT)
  ) u_decoder (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .mode_select_low_pin_i(mode_select_low_pin_i),
    .mode_select_high_pin_i(mode_select_high_pin_i),
    .mif(mif.src)
  );

  // State and registers
  seq_state_t state_r;
  seq_state_t state_nxt;
  power_mode_t mode_r;
  power_mode_t mode_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] mask_r;
  logic [7:0] thresh_r;
  logic [7:0] cfg2_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] restore_cnt_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq2_n_r;
  logic second_interrupt_out_n_r;
  logic busy_r;

  // Address decode
  wire hit_ctrl = (reg_addr_i == `OFS_CTRL);
  wire hit_mask = (reg_addr_i == `OFS_MASK);
  wire hit_thresh = (reg_addr_i == `OFS_THRESH);
  wire hit_cfg2 = (reg_addr_i == `OFS_CFG2);
  wire hit_status = (reg_addr_i == `OFS_STATUS);
  wire hit_clear = (reg_addr_i == `OFS_CLEAR);
  wire hit_mode = (reg_addr_i == `OFS_MODE);
  wire hit_count = (reg_addr_i == `OFS_COUNT);

  // Sequencer events
  wire in_restore = (state_r == st_restore);
  wire wake_start = (state_r != st_restore) && mif.change &&
                    (mif.req_mode == normal_power_mode) && (mode_r != normal_power_mode);
  wire abort = in_restore && mif.change && (mif.req_mode != normal_power_mode);
  wire restore_end = in_restore && !abort && (cnt_r == CNT_LAST);
  wire done_set = (state_r == st_finish);

  // Writes to reloadable registers are refused while a restore runs
  wire wr_ctrl = reg_wr_i && hit_ctrl && !in_restore;
  wire wr_mask = reg_wr_i && hit_mask && !in_restore;
  wire wr_thresh = reg_wr_i && hit_thresh;
  wire wr_cfg2 = reg_wr_i && hit_cfg2;

  // Software clear through write-one on status or the clear register
  wire [15:0] sw_clear = (reg_wr_i && (hit_status || hit_clear)) ? reg_wdata_i[15:0] : 16'h0000;

  // Hardware event set vector
  wire ev_mode = mif.change && ctrl_r[`BIT_CTRL_REPORT];
  wire ev_unsup = mif.change && mif.unsupported;
  wire [15:0] hw_set = (16'(ev_mode) << `BIT_MODE_CHANGE) |
                       (16'(ev_unsup) << `BIT_UNSUPPORTED) |
                       (16'(done_set) << `BIT_DONE);

  // Done flag is forced low when a transition begins
  wire [15:0] hw_clear = wake_start ? (16'h0001 << `BIT_DONE) : 16'h0000;

  // Interrupt combine; mask bit 15 ignored so done is unmaskable
  wire [15:0] mask_eff = {1'b0, mask_r[14:0]};
  wire irq2_active = status_nxt[`BIT_DONE] || (|(status_nxt & mask_eff));

  // Next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    case (state_r)
      st_idle: begin
        if (wake_start) begin
          state_nxt = st_restore;
          mode_nxt = normal_power_mode;
          cnt_nxt = '0;
        end else if (mif.change) begin
          mode_nxt = mif.req_mode;
        end
      end
      st_restore: begin
        if (abort) begin
          state_nxt = st_idle;
          mode_nxt = mif.req_mode;
        end else if (restore_end) begin
          state_nxt = st_finish;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      st_finish: begin
        state_nxt = st_idle;
        if (mif.change) begin
          mode_nxt = mif.req_mode;
        end
      end
      default: begin
        state_nxt = st_idle;
      end
    endcase
  end

  // Status update: set wins over any clear in the same cycle
  always_comb begin
    status_nxt = (status_r & ~sw_clear & ~hw_clear) | hw_set;
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_nxt = {16'h0000, ctrl_r};
    end else if (hit_mask) begin
      rdata_nxt = {16'h0000, mask_r};
    end else if (hit_thresh) begin
      rdata_nxt = {24'h00_0000, thresh_r};
    end else if (hit_cfg2) begin
      rdata_nxt = {24'h00_0000, cfg2_r};
    end else if (hit_status) begin
      rdata_nxt = {16'h0000, status_r};
    end else if (hit_mode) begin
      rdata_nxt = {26'h000_0000, FULL_VARIANT, busy_r, mif.raw_code, mode_r};
    end else if (hit_count) begin
      rdata_nxt = {16'h0000, restore_cnt_r};
    end
  end

  // Sequencer state registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r <= st_idle;
      mode_r <= sleep_power_mode;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Control register: reset or wake reloads default
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wake_start) begin
      ctrl_r <= CTRL_DEFAULT;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata_i[15:0];
    end
  end

  // Interrupt mask register: reset or wake reloads default
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || wake_start) begin
      mask_r <= MASK_DEFAULT;
    end else if (wr_mask) begin
      mask_r <= reg_wdata_i[15:0];
    end
  end

  // Threshold and second config keep their contents across a wake
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      thresh_r <= `RST_THRESH;
      cfg2_r <= `RST_CFG2;
    end else begin
      if (wr_thresh) begin
        thresh_r <= reg_wdata_i[7:0];
      end
      if (wr_cfg2) begin
        cfg2_r <= reg_wdata_i[7:0];
      end
    end
  end

  // Sticky status bits
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status_r <= 16'h0000;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Count of completed restores, saturating
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      restore_cnt_r <= 16'h0000;
    end else if (done_set && restore_cnt_r != 16'hFFFF) begin
      restore_cnt_r <= restore_cnt_r + 16'h0001;
    end
  end

  // Registered read data, valid the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // Active-low interrupt outputs; first one has no source in this block
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq2_n_r <= 1'b1;
      second_interrupt_out_n_r <= 1'b1;
    end else begin
      irq2_n_r <= !irq2_active;
      second_interrupt_out_n_r <= 1'b1;
    end
  end

  // Busy flag mirrors the restore period
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt == st_restore);
    end
  end

  assign reg_rdata_o = rdata_r;
  assign first_interrupt_out_n_o = second_interrupt_out_n_r;
  assign second_interrupt_out_n_o = irq2_n_r;
  assign power_mode_o = mode_r;
  assign transition_busy_o = busy_r;

endmodule
`default_nettype wire

// ==== bench/mode_pin_driver.sv ====
// Processor model driving the two mode-select pins
`timescale 1ns/10ps
`default_nettype none
module mode_pin_driver (
  input wire logic drive_en_i,
  input wire logic [1:0] code_i,
  output logic mode_select_low_pin_o,
  output logic mode_select_high_pin_o
);
  // Released pins float up to the pull-up level
  assign mode_select_high_pin_o = drive_en_i ? code_i[1] : 1'b1;
  assign mode_select_low_pin_o = drive_en_i ? code_i[0] : 1'b1;
endmodule
`default_nettype wire

// ==== bench/pms_chk.sv ====
// Port checks for the power mode sequencer
`timescale 1ns/10ps
`default_nettype none
module pms_chk #(parameter int RESTORE_CYCLES = 16) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic first_interrupt_out_n_o,
  input wire logic second_interrupt_out_n_o,
  input wire logic [1:0] power_mode_o,
  input wire logic transition_busy_o
);
  logic [15:0] busy_cnt_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Counts the cycles of the running restore
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !transition_busy_o) busy_cnt_r <= 16'h0000;
    else busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  property p_rst;
    disable iff (1'b0) sys_rst_i |=> power_mode_o == 2'h3 && second_interrupt_out_n_o
      && first_interrupt_out_n_o && !transition_busy_o && reg_rdata_o == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_irq_first;
    first_interrupt_out_n_o;
  endproperty
  a_irq_first: assert property (p_irq_first) else $error("first irq asserted");
  property p_enter;
    $rose(transition_busy_o) |-> power_mode_o == 2'h1;
  endproperty
  a_enter: assert property (p_enter) else $error("restore not into normal");
  property p_len;
    $fell(transition_busy_o) && power_mode_o == 2'h1 |-> busy_cnt_r == 16'(RESTORE_CYCLES);
  endproperty
  a_len: assert property (p_len) else $error("restore length wrong");
  property p_done;
    $fell(transition_busy_o) && power_mode_o == 2'h1 |-> ##2 !second_interrupt_out_n_o;
  endproperty
  a_done: assert property (p_done) else $error("no irq after restore");
  property p_quiet;
    transition_busy_o && $past(transition_busy_o) |-> second_interrupt_out_n_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq during restore");
  property p_rd_busy;
    reg_rd_i && reg_addr_i == 8'h10 && transition_busy_o |=> !reg_rdata_o[15];
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("done set during restore");
  property p_clear;
    reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i[15:0] == 16'hFFFF && !transition_busy_o
      && !$past(transition_busy_o) |-> ##2 second_interrupt_out_n_o;
  endproperty
  a_clear: assert property (p_clear) else $error("irq not released");
  c_done: cover property ($fell(second_interrupt_out_n_o));
  c_rd_busy: cover property (reg_rd_i && transition_busy_o);
  c_wake: cover property ($rose(transition_busy_o));
endmodule
bind power_mode_select_sequencer pms_chk #(.RESTORE_CYCLES(RESTORE_CYCLES)) pms_chk_inst (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .first_interrupt_out_n_o(first_interrupt_out_n_o),
  .second_interrupt_out_n_o(second_interrupt_out_n_o), .power_mode_o(power_mode_o),
  .transition_busy_o(transition_busy_o));
`default_nettype wire

// ==== bench/tb_power_mode_select_sequencer.sv ====
// Self-checking bench for the power mode sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_power_mode_select_sequencer;
  logic core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, drv_en, rd_d, first_interrupt_out_n, irq2_n, busy;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, r1, r2;
  logic [1:0] code, power_mode_o;
  logic [1:0] mode_tab[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [63:0] exp_q[$];
  logic [63:0] note;
  wire logic lo_pin, hi_pin;
  int err_count, tests_run, cyc, seed;
  mode_pin_driver mode_pin_driver_inst (.drive_en_i(drv_en), .code_i(code),
    .mode_select_low_pin_o(lo_pin), .mode_select_high_pin_o(hi_pin));
  power_mode_select_sequencer #(.RESTORE_CYCLES(8)) power_mode_select_sequencer_inst (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .mode_select_low_pin_i(lo_pin),
    .mode_select_high_pin_i(hi_pin), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .first_interrupt_out_n_o(first_interrupt_out_n), .second_interrupt_out_n_o(irq2_n),
    .power_mode_o(power_mode_o), .transition_busy_o(busy));
  // Clock at 200 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic miss(input logic [31:0] got, input logic [31:0] exp);
    err_count++;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== exp) miss(got, exp);
  endtask
  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) miss({30'h0, got}, {30'h0, exp});
  endtask
  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] c, input int n);
    @(posedge core_clk_i);
    drv_en <= 1'b1;
    code <= c;
    repeat (n) @(posedge core_clk_i);
  endtask
  // Read notes are taken off the queue when the read slot comes
  always @(posedge core_clk_i) rd_d <= reg_rd_i;
  always @(negedge core_clk_i) begin
    if (rd_d === 1'b1) begin
      note = exp_q.pop_front();
      cmp_rd(reg_rdata_o, note[31:0], note[63:32]);
    end
  end
  // Hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    seed = 5355;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    drv_en = 1'b0;
    code = 2'h3;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    cmp_pin(power_mode_o, 2'h3);
    foreach (mode_tab[i]) begin
      pins(mode_tab[i], 8);
      cmp_pin(power_mode_o, mode_tab[i]);
    end
    for (int i = 0; i < 60 && irq2_n !== 1'b0; i++) @(negedge core_clk_i);
    cmp_pin({1'b0, irq2_n}, 2'h0);
    rd(8'h10, 32'h8000, 32'h8000);
    wr(8'h10, 32'hFFFF);
    repeat (3) @(posedge core_clk_i);
    cmp_pin({first_interrupt_out_n, irq2_n}, 2'h3);
    r1 = $random(seed);
    r2 = $random(seed);
    wr(8'h00, {16'h0, r1[15:1], 1'b1});
    wr(8'h04, 32'h0001);
    wr(8'h08, {24'h0, r1[23:16]});
    wr(8'h0C, {24'h0, r2[7:0]});
    wr(8'hFC, r2);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    pins(2'h3, 8);
    cmp_pin({1'b0, irq2_n}, 2'h0);
    wr(8'h14, 32'hFFFF);
    repeat (3) @(posedge core_clk_i);
    cmp_pin({1'b0, irq2_n}, 2'h1);
    pins(2'h1, 0);
    for (int i = 0; i < 60 && busy !== 1'b1; i++) @(negedge core_clk_i);
    wr(8'h00, 32'h5555);
    rd(8'h10, 32'h0, 32'h8000);
    for (int i = 0; i < 60 && irq2_n !== 1'b0; i++) @(negedge core_clk_i);
    rd(8'h00, 32'h0001, 32'hFFFFFFFF);
    rd(8'h04, 32'h0000, 32'hFFFFFFFF);
    rd(8'h08, {24'h0, r1[23:16]}, 32'hFFFFFFFF);
    rd(8'h0C, {24'h0, r2[7:0]}, 32'hFFFFFFFF);
    rd(8'h10, 32'h8000, 32'h8000);
    rd(8'h1C, 32'h0002, 32'hFFFFFFFF);
    rd(8'h18, 32'h0025, 32'hFFFFFFFF);
    // Hardware reset in mid-run brings kept registers back to defaults
    sys_rst_i <= 1'b1;
    drv_en <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(8'h08, 32'h0007, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0000, 32'hFFFFFFFF);
    rd(8'h10, 32'h0000, 32'hFFFFFFFF);
    repeat (4) @(posedge core_clk_i);
    cmp_pin(power_mode_o, 2'h3);
    cmp_pin({first_interrupt_out_n, irq2_n}, 2'h3);
    finish_test();
  end
endmodule
`default_nettype wire
